// ---- include/ddr3_mpr_defs.svh ----
// Shared constants for the DDR3 readout link: pin fields, patterns, timing and controller register map
`ifndef DDR3_MPR_DEFS_SVH
`define DDR3_MPR_DEFS_SVH
// Bank codes of a mode register set
`define MRS_BA_MR0 3'h0
`define MRS_BA_MR3 3'h3
// Address pin fields
`define A_LOC 1:0
`define A_EN 2
`define A_NIB 2
`define A_COL_LSB 3
`define A_AP 10
`define A_BC 12
`define A_BL 1:0
// Burst length field of mode register zero
`define MR0_BL_FIXED8 2'h0
`define MR0_BL_OTF 2'h1
`define MR0_BL_FIXED4 2'h2
// Readout locations and their patterns, beat 0 in the LSB
`define LOC_CAL 2'h0
`define PAT_CAL 8'haa
`define PAT_RFU 8'h00
// Beats per burst
`define BEATS_FULL 4'h8
`define BEATS_CHOP 4'h4
// Default latencies in clock cycles
`define DEF_RL 6
`define DEF_WL 5
// Timing
`define CLK_PERIOD_PS 20000
`define TRP_NS 15
`define TRP_CYC ((`TRP_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define DLLK_CYC 512
// Controller register offsets
`define REG_CTRL 4'h0
`define REG_STAT 4'h1
`define REG_WDATA 4'h2
`define REG_CAP_BIT 3
// Controller command register fields
`define CF_OP 1:0
`define CF_EN 2
`define CF_LOC 4:3
`define CF_BL 6:5
`define CF_CHOP 7
`define CF_UPPER 8
`define CF_COL 12:9
// Controller status register bits
`define SF_BUSY 0
`define SF_ON 1
`define SF_LOCK 2
`define SF_REFUSED 3
`endif

// ---- include/ddr3_mpr_pkg.sv ----
// Types and command coding shared by both ends of the DDR3 readout link
package ddr3_mpr_pkg;
   // Decoded command on the command pins
   typedef enum logic [3:0] {CMD_DES, CMD_NOP, CMD_MRS, CMD_REF, CMD_PRE, CMD_ACT, CMD_WR, CMD_RD, CMD_ZQ} cmd_t;
   // Controller operations, in the order of the command field
   typedef enum logic [1:0] {OP_MR3, OP_MR0, OP_RD, OP_WR} op_t;

   // Pins {cs_n, ras_n, cas_n, we_n} to a command
   function automatic cmd_t decode_cmd(input logic [3:0] pins);
      cmd_t c;
      c = CMD_DES;
      if (!pins[3])
      begin
         unique case (pins[2:0])
            3'h0: c = CMD_MRS;
            3'h1: c = CMD_REF;
            3'h2: c = CMD_PRE;
            3'h3: c = CMD_ACT;
            3'h4: c = CMD_WR;
            3'h5: c = CMD_RD;
            3'h6: c = CMD_ZQ;
            3'h7: c = CMD_NOP;
         endcase
      end
      return c;
   endfunction : decode_cmd

   // Command to pins {cs_n, ras_n, cas_n, we_n}
   function automatic logic [3:0] encode_cmd(input cmd_t c);
      logic [3:0] p;
      p = 4'hf;
      unique case (c)
         CMD_MRS: p = 4'h0;
         CMD_REF: p = 4'h1;
         CMD_PRE: p = 4'h2;
         CMD_ACT: p = 4'h3;
         CMD_WR: p = 4'h4;
         CMD_RD: p = 4'h5;
         CMD_ZQ: p = 4'h6;
         CMD_NOP: p = 4'h7;
         CMD_DES: p = 4'hf;
      endcase
      return p;
   endfunction : encode_cmd
endpackage : ddr3_mpr_pkg

// ---- include/ddr3_link_if.sv ----
// Command, address and data link between the DDR3 controller and the device
`timescale 1ns/10ps
`default_nettype none
interface ddr3_link_if #(
   parameter int DQ_W = 8
);
   logic rst_n;         // Device reset, low active
   logic cke;           // Clock enable, high after reset
   logic cs_n;          // Chip select, low active
   logic ras_n;         // Row strobe, low active
   logic cas_n;         // Column strobe, low active
   logic we_n;          // Write enable, low active
   logic [2:0] ba;      // Bank bits
   logic [15:0] addr;   // Address bits
   logic [DQ_W-1:0] dq_ctl;   // Data driven by the controller
   logic dq_ctl_oe;     // Controller drives data
   logic [DQ_W-1:0] dq_dev;   // Data driven by the device
   logic dq_dev_oe;     // Device drives data
   logic dqs_dev;       // Device read beat marker
   logic [DQ_W-1:0] dq; // Resolved data wire

   // Wire level from the two enables, idle bus reads zero
   assign dq = dq_dev_oe ? dq_dev : (dq_ctl_oe ? dq_ctl : '0);

   modport device (
      input rst_n, cke, cs_n, ras_n, cas_n, we_n, ba, addr, dq,
      output dq_dev, dq_dev_oe, dqs_dev
   );
   modport ctrl (
      output rst_n, cke, cs_n, ras_n, cas_n, we_n, ba, addr, dq_ctl, dq_ctl_oe,
      input dq, dq_dev_oe, dqs_dev
   );
endinterface : ddr3_link_if
`default_nettype wire

// ---- hdl/ddr3_mpr_ctrl.sv ----
// DDR3 controller end: mode register writes, readout entry and exit, reads and writes
`timescale 1ns/10ps
`default_nettype none
`include "ddr3_mpr_defs.svh"
module ddr3_mpr_ctrl
   import ddr3_mpr_pkg::*;
#(
   parameter int DQ_W = 8,
   parameter int RL = `DEF_RL,
   parameter int WL = `DEF_WL,
   parameter int TRP_CYC = `TRP_CYC,
   parameter int DLLK_CYC = `DLLK_CYC
)
(
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic [3:0] reg_addr_i,
   input wire logic [15:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [15:0] reg_rdata_o,
   ddr3_link_if.ctrl link
);
   localparam int CW = $clog2(RL + WL + 10);
   localparam int KW = $clog2(DLLK_CYC + 1);
   localparam int TW = $clog2(TRP_CYC + 1);

   typedef enum logic [1:0] {C_IDLE, C_TRP, C_XFER} ctl_state_t;
   ctl_state_t state_q, nxt_d;
   cmd_t cmd_d;
   logic [15:0] addr_d;        // Next address pins
   logic [2:0] ba_d;           // Next bank pins
   logic [15:0] ctrl_q;        // Order being worked on
   logic [15:0] cf_w;          // Order fields seen this cycle
   op_t op_w;
   logic go_w, wr_ctrl_w, illegal_w, need_pre_w, chop_w, wact_w, done_w;
   logic [15:0] mrs_addr_w, rw_addr_w;
   logic [2:0] mrs_ba_w;
   logic [3:0] nb_w;
   logic [CW-1:0] cnt_q, wrel_w;
   logic [3:0] beats_q;        // Beats captured so far
   logic [TW-1:0] wait_q;      // Precharge wait
   logic [KW-1:0] dll_q;       // Lock wait
   logic locked_q, on_q, refused_q;
   logic [1:0] bl_q;           // Burst mode last written
   logic [DQ_W-1:0] wdata_q, dq_q;
   logic [DQ_W-1:0] cap_q [8];
   logic dq_oe_q, cke_q, rst_n_q;
   logic [3:0] pins_q;
   logic [15:0] addr_q;
   logic [2:0] ba_q;
   logic [15:0] rdata_d, rdata_q;

   // Order fields and their legality
   assign wr_ctrl_w = reg_wr_i && (reg_addr_i == `REG_CTRL);
   assign cf_w = (state_q == C_IDLE) ? reg_wdata_i : ctrl_q;
   assign op_w = op_t'(cf_w[`CF_OP]);
   assign illegal_w = (on_q && (op_w == OP_MR0 || op_w == OP_WR))
      || (op_w == OP_RD && !locked_q)
      || (op_w == OP_MR3 && cf_w[`CF_EN] && cf_w[`CF_LOC] != `LOC_CAL);
   assign go_w = wr_ctrl_w && (state_q == C_IDLE) && !illegal_w;
   // Entry needs all banks idle; no precharge may follow once readout is on
   assign need_pre_w = (op_w == OP_MR0) || (op_w == OP_MR3 && cf_w[`CF_EN] && !on_q);
   // Mode register words with reserved bits zero
   assign mrs_addr_w = (op_w == OP_MR3) ? {13'h0000, cf_w[`CF_EN], cf_w[`CF_LOC]}
      : {14'h0000, cf_w[`CF_BL]};
   assign mrs_ba_w = (op_w == OP_MR3) ? `MRS_BA_MR3 : `MRS_BA_MR0;
   // Read and write address: low column bits zero, nibble only when chopped
   assign chop_w = (bl_q == `MR0_BL_FIXED4) || (bl_q == `MR0_BL_OTF && cf_w[`CF_CHOP]);
   assign rw_addr_w = {3'h0, !cf_w[`CF_CHOP], 5'h00, cf_w[`CF_COL], chop_w && cf_w[`CF_UPPER], 2'h0};
   assign nb_w = chop_w ? `BEATS_CHOP : `BEATS_FULL;
   // Write beats by own count, reads end on captured beats or a stall
   assign wrel_w = cnt_q - CW'(WL);
   assign wact_w = (op_w == OP_WR) && (cnt_q >= CW'(WL)) && (wrel_w < CW'(nb_w));
   assign done_w = (op_w == OP_WR) ? (wact_w && wrel_w[3:0] == nb_w - 4'h1)
      : ((beats_q == nb_w) || (cnt_q == '1));

   // Next command and state
   always_comb
   begin
      nxt_d = state_q;
      cmd_d = CMD_DES;
      addr_d = 16'h0000;
      ba_d = 3'h0;
      unique case (state_q)
         C_IDLE:
            if (go_w && need_pre_w)
            begin
               cmd_d = CMD_PRE;
               addr_d[`A_AP] = 1'b1;
               nxt_d = C_TRP;
            end
            else if (go_w && (op_w == OP_MR3 || op_w == OP_MR0))
            begin
               cmd_d = CMD_MRS;
               addr_d = mrs_addr_w;
               ba_d = mrs_ba_w;
            end
            else if (go_w)
            begin
               cmd_d = (op_w == OP_RD) ? CMD_RD : CMD_WR;
               addr_d = rw_addr_w;
               nxt_d = C_XFER;
            end
         C_TRP:
            if (wait_q == '0)
            begin
               cmd_d = CMD_MRS;
               addr_d = mrs_addr_w;
               ba_d = mrs_ba_w;
               nxt_d = C_IDLE;
            end
         C_XFER:
            if (done_w)
            begin
               nxt_d = C_IDLE;
            end
      endcase
   end

   // Register read selection
   assign rdata_d = reg_addr_i[`REG_CAP_BIT] ? 16'(cap_q[reg_addr_i[2:0]])
      : (reg_addr_i == `REG_STAT) ? {12'h000, refused_q, locked_q, on_q, state_q != C_IDLE}
      : (reg_addr_i == `REG_WDATA) ? 16'(wdata_q) : 16'h0000;

   // Sequencer, pins and software registers
   always_ff @(posedge core_clk_i)
   begin
      if (reset_i)
      begin
         state_q <= C_IDLE;
         ctrl_q <= 16'h0000;
         cnt_q <= '0;
         beats_q <= 4'h0;
         wait_q <= '0;
         dll_q <= '0;
         locked_q <= 1'b0;
         on_q <= 1'b0;
         refused_q <= 1'b0;
         bl_q <= `MR0_BL_FIXED8;
         wdata_q <= '0;
         dq_q <= '0;
         dq_oe_q <= 1'b0;
         cke_q <= 1'b0;
         rst_n_q <= 1'b0;
         pins_q <= 4'hf;
         addr_q <= 16'h0000;
         ba_q <= 3'h0;
         rdata_q <= 16'h0000;
      end
      else
      begin
         state_q <= nxt_d;
         rst_n_q <= 1'b1;
         cke_q <= 1'b1;
         pins_q <= encode_cmd(cmd_d);
         addr_q <= addr_d;
         ba_q <= ba_d;
         rdata_q <= reg_rd_i ? rdata_d : 16'h0000;
         // Lock wait after the device reset
         if (!locked_q)
         begin
            dll_q <= dll_q + KW'(1);
            locked_q <= (dll_q == KW'(DLLK_CYC - 1));
         end
         // Refusal is sticky; a new refusal wins over the status read clear
         if (wr_ctrl_w && (state_q != C_IDLE || illegal_w))
            refused_q <= 1'b1;
         else if (reg_rd_i && reg_addr_i == `REG_STAT)
            refused_q <= 1'b0;
         if (reg_wr_i && reg_addr_i == `REG_WDATA)
            wdata_q <= reg_wdata_i[DQ_W-1:0];
         if (go_w)
         begin
            ctrl_q <= reg_wdata_i;
            cnt_q <= CW'(1);
            beats_q <= 4'h0;
            wait_q <= TW'(TRP_CYC - 1);
         end
         else if (state_q == C_TRP)
            wait_q <= wait_q - TW'(1);
         else if (state_q == C_XFER && cnt_q != '1)
            cnt_q <= cnt_q + CW'(1);
         // Track the mode that was written
         if (cmd_d == CMD_MRS && op_w == OP_MR3)
            on_q <= cf_w[`CF_EN];
         if (cmd_d == CMD_MRS && op_w == OP_MR0)
            bl_q <= cf_w[`CF_BL];
         // Write beats, distinct per beat
         dq_oe_q <= (state_q == C_XFER) && wact_w;
         dq_q <= wact_w ? wdata_q + DQ_W'(wrel_w[2:0]) : '0;
         // Read beats as marked by the device
         if (state_q == C_XFER && op_w == OP_RD && link.dqs_dev && beats_q != nb_w)
         begin
            cap_q[beats_q[2:0]] <= link.dq;
            beats_q <= beats_q + 4'h1;
         end
      end
   end

   assign link.rst_n = rst_n_q;
   assign link.cke = cke_q;
   assign {link.cs_n, link.ras_n, link.cas_n, link.we_n} = pins_q;
   assign link.addr = addr_q;
   assign link.ba = ba_q;
   assign link.dq_ctl = dq_q;
   assign link.dq_ctl_oe = dq_oe_q;
   assign reg_rdata_o = rdata_q;
endmodule : ddr3_mpr_ctrl
`default_nettype wire

// ---- hdl/ddr3_mpr_device.sv ----
// DDR3 device end: mode register three, burst length, bank state, array and readout bursts
`timescale 1ns/10ps
`default_nettype none
`include "ddr3_mpr_defs.svh"
module ddr3_mpr_device
   import ddr3_mpr_pkg::*;
#(
   parameter int DQ_W = 8,
   parameter int RL = `DEF_RL,
   parameter int WL = `DEF_WL,
   parameter int ARR_AW = 4,
   parameter bit REPLICATE = 1'b1
)
(
   input wire logic core_clk_i,
   input wire logic reset_i,
   ddr3_link_if.device link,
   output logic readout_mode_o,
   output logic [1:0] readout_loc_o,
   output logic [1:0] bl_mode_o,
   output logic [7:0] banks_open_o
);
   // Byte lanes and burst counter width
   localparam int LANES = DQ_W / 8;
   localparam int CW = $clog2(RL + WL + 10);

   // Burst engine states
   typedef enum logic [1:0] {S_IDLE, S_RD, S_WR} dev_state_t;
   dev_state_t state_q;

   logic rst_w;                 // Core reset or link reset
   cmd_t cmd_w;                 // Command in this cycle
   logic mr3_wr_w;              // Write to mode register three
   logic mr0_wr_w;              // Write to mode register zero
   logic rd_go_w;               // Read taken
   logic wr_go_w;               // Write taken
   logic chop_w;                // Command asks for a chopped burst
   logic mpr_en_q;              // Readout mode enabled
   logic [1:0] loc_q;           // Readout location
   logic [1:0] bl_mode_q;       // Burst length field
   logic [CW-1:0] cnt_q;        // Cycles since the command
   logic [CW-1:0] base_w;       // Count of the first beat
   logic [CW-1:0] rel_w;        // Beat number relative to start
   logic [3:0] nbeat_q;         // Beats in this burst
   logic nib_q;                 // Upper nibble start
   logic src_mpr_q;             // Burst served from the readout pattern
   logic ap_q;                  // Auto precharge at burst end
   logic [2:0] bank_q;          // Bank of the burst
   logic [ARR_AW-1:0] col_q;    // Array burst index
   logic active_w;              // A beat is due this cycle
   logic done_w;                // Last beat this cycle
   logic [2:0] beat_w;          // Beat position in the eight
   logic [7:0] pat_w;           // Pattern of the selected location
   logic mpr_bit_w;             // Readout bit of this beat
   logic [DQ_W-1:0] lane_w;     // Readout bit spread on the lanes
   logic [DQ_W-1:0] mem_rd_w;   // Array word of this beat
   logic [DQ_W-1:0] dq_d;       // Next read data
   logic [DQ_W-1:0] dq_q;       // Read data flop
   logic dq_oe_q;               // Read drive enable flop
   logic dqs_q;                 // Read beat marker flop
   logic [7:0] banks_q;         // Open banks
   logic [DQ_W-1:0] mem_q [2**(ARR_AW+3)]; // Array storage

   // Link reset clears the device like the core reset
   assign rst_w = reset_i || !link.rst_n;

   // Command decode; nothing is taken with the clock enable low
   assign cmd_w = link.cke ? decode_cmd({link.cs_n, link.ras_n, link.cas_n, link.we_n}) : CMD_DES;
   assign mr3_wr_w = (cmd_w == CMD_MRS) && (link.ba == `MRS_BA_MR3);
   assign mr0_wr_w = (cmd_w == CMD_MRS) && (link.ba == `MRS_BA_MR0);

   // Reads always taken when idle; writes ignored while readout is on
   assign rd_go_w = (state_q == S_IDLE) && (cmd_w == CMD_RD);
   assign wr_go_w = (state_q == S_IDLE) && (cmd_w == CMD_WR) && !mpr_en_q;

   // Chop always in fixed four mode, from the pin in on-the-fly mode, low pin means chopped
   assign chop_w = (bl_mode_q == `MR0_BL_FIXED4)
      || (bl_mode_q == `MR0_BL_OTF && !link.addr[`A_BC]);

   // Beat window: reads lead by one for the output flop
   assign base_w = (state_q == S_RD) ? CW'(RL - 1) : CW'(WL);
   assign rel_w = cnt_q - base_w;
   assign active_w = (state_q != S_IDLE) && (cnt_q >= base_w) && (rel_w < CW'(nbeat_q));
   assign done_w = active_w && (rel_w[3:0] == nbeat_q - 4'h1);

   // Beat position: nibble start plus sequential offset
   assign beat_w = {nib_q, 2'h0} + rel_w[2:0];

   // Readout bit: LSB first, reserved locations read zero
   assign pat_w = (loc_q == `LOC_CAL) ? `PAT_CAL : `PAT_RFU;
   assign mpr_bit_w = pat_w[beat_w];

   // Bit on line 0 of each lane, other lines copy it or stay zero
   generate
      for (genvar l = 0; l < LANES; l++)
      begin : g_lane
         assign lane_w[l*8] = mpr_bit_w;
         assign lane_w[l*8+7:l*8+1] = REPLICATE ? {7{mpr_bit_w}} : 7'h00;
      end
   endgenerate

   // Data source picked at command time
   assign mem_rd_w = mem_q[{col_q, beat_w}];
   assign dq_d = src_mpr_q ? lane_w : mem_rd_w;

   // Mode registers
   always_ff @(posedge core_clk_i)
   begin
      if (rst_w)
      begin
         mpr_en_q <= 1'b0;
         loc_q <= `LOC_CAL;
         bl_mode_q <= `MR0_BL_FIXED8;
      end
      else
      begin
         // Location kept but unused while readout is off
         if (mr3_wr_w)
         begin
            mpr_en_q <= link.addr[`A_EN];
            loc_q <= link.addr[`A_LOC];
         end
         if (mr0_wr_w)
            bl_mode_q <= link.addr[`A_BL];
      end
   end

   // Burst engine: command capture and beat counting
   always_ff @(posedge core_clk_i)
   begin
      if (rst_w)
      begin
         state_q <= S_IDLE;
         cnt_q <= '0;
         nbeat_q <= `BEATS_FULL;
         nib_q <= 1'b0;
         src_mpr_q <= 1'b0;
         ap_q <= 1'b0;
         bank_q <= 3'h0;
         col_q <= '0;
      end
      else if (rd_go_w || wr_go_w)
      begin
         state_q <= rd_go_w ? S_RD : S_WR;
         cnt_q <= CW'(1);
         nbeat_q <= chop_w ? `BEATS_CHOP : `BEATS_FULL;
         // Full bursts always start at beat 0
         nib_q <= chop_w && link.addr[`A_NIB];
         src_mpr_q <= mpr_en_q;
         // Readout drops precharge flag and upper columns, bank still taken from the pins
         ap_q <= link.addr[`A_AP] && !mpr_en_q;
         bank_q <= link.ba;
         col_q <= mpr_en_q ? '0 : link.addr[`A_COL_LSB+ARR_AW-1:`A_COL_LSB];
      end
      else if (state_q != S_IDLE)
      begin
         cnt_q <= cnt_q + CW'(1);
         // Back to idle after the last beat
         if (done_w)
            state_q <= S_IDLE;
      end
   end

   // Read output stage, driven only during read beats
   always_ff @(posedge core_clk_i)
   begin
      if (rst_w)
      begin
         dq_q <= '0;
         dq_oe_q <= 1'b0;
         dqs_q <= 1'b0;
      end
      else
      begin
         dq_q <= (state_q == S_RD && active_w) ? dq_d : '0;
         dq_oe_q <= (state_q == S_RD) && active_w;
         dqs_q <= (state_q == S_RD) && active_w;
      end
   end

   // Array write beats, no reset on storage
   always_ff @(posedge core_clk_i)
   begin
      if (!rst_w && state_q == S_WR && active_w)
         mem_q[{col_q, beat_w}] <= link.dq;
   end

   // Bank state: activate opens, precharge closes, auto precharge at the end
   always_ff @(posedge core_clk_i)
   begin
      if (rst_w)
         banks_q <= 8'h00;
      else
      begin
         if (cmd_w == CMD_ACT)
            banks_q[link.ba] <= 1'b1;
         else if (cmd_w == CMD_PRE && link.addr[`A_AP])
            banks_q <= 8'h00;
         else if (cmd_w == CMD_PRE)
            banks_q[link.ba] <= 1'b0;
         // Never reached for readout bursts
         if (done_w && ap_q)
            banks_q[bank_q] <= 1'b0;
      end
   end

   assign link.dq_dev = dq_q;
   assign link.dq_dev_oe = dq_oe_q;
   assign link.dqs_dev = dqs_q;
   assign readout_mode_o = mpr_en_q;
   assign readout_loc_o = loc_q;
   assign bl_mode_o = bl_mode_q;
   assign banks_open_o = banks_q;
endmodule : ddr3_mpr_device
`default_nettype wire

// ---- dv/ddr3_mpr_assertions.sv ----
// Checker on the link between the DDR3 controller and device
`timescale 1ns/10ps
`default_nettype none
module ddr3_mpr_assertions (
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic rst_n,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic [2:0] ba,
   input wire logic [15:0] addr,
   input wire logic [7:0] dq,
   input wire logic dq_dev_oe,
   input wire logic dqs_dev
);
   logic mode_q; // Readout mode seen on the pins
   logic otf_q; // On-the-fly burst length set
   logic [3:0] beat_q; // Beat index in a burst
   wire mrs = !cs_n && !ras_n && !cas_n && !we_n;
   wire rd = !cs_n && ras_n && !cas_n && we_n;
   wire pre_all = !cs_n && !ras_n && cas_n && !we_n && addr[10];
   wire idle = cs_n || (ras_n && cas_n && we_n);
   wire mrs3 = mrs && (ba == 3'h3);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (reset_i);
   // Follow mode writes and count beats
   always_ff @(posedge core_clk_i)
   begin
      if (reset_i || !rst_n)
      begin
         mode_q <= 1'b0;
         otf_q <= 1'b0;
         beat_q <= 4'h0;
      end
      else
      begin
         mode_q <= mrs3 ? addr[2] : mode_q;
         otf_q <= (mrs && ba == 3'h0) ? (addr[1:0] == 2'h1) : otf_q;
         beat_q <= dqs_dev ? beat_q + 4'h1 : 4'h0;
      end
   end
   sequence s_full;
      dqs_dev [*8] ##1 !dqs_dev;
   endsequence
   sequence s_chop;
      dqs_dev [*4] ##1 !dqs_dev;
   endsequence
   a_mr3_reserved_zero: assert property (mrs3 |-> addr[15:3] == 13'h0) else $error("reserved bits set");
   a_mr3_loc_zero: assert property (mrs3 && addr[2] |-> addr[1:0] == 2'h0) else $error("bad location");
   a_entry_after_pre: assert property (mrs3 && addr[2] && !mode_q |-> $past(pre_all)) else $error("no precharge");
   a_only_reads: assert property (mode_q |-> idle || rd || mrs3) else $error("bad command");
   a_full_burst: assert property (mode_q && rd && addr[12] |-> ##6 s_full) else $error("bad full burst");
   a_chop_burst: assert property (mode_q && otf_q && rd && !addr[12] |-> ##6 s_chop) else $error("bad chop");
   a_pattern_bit: assert property (mode_q && dqs_dev |-> dq[0] == beat_q[0]) else $error("bad pattern");
   a_lane_copy: assert property (mode_q && dqs_dev |-> dq[7:1] == {7{dq[0]}}) else $error("bad lanes");
   a_reset_quiet: assert property ($fell(reset_i) |-> !dq_dev_oe && !dqs_dev) else $error("drives in reset");
endmodule : ddr3_mpr_assertions
`default_nettype wire

// ---- dv/tb_top.sv ----
// Testbench driving the controller registers with the device on the link
`timescale 1ns/10ps
`default_nettype none
`include "ddr3_mpr_defs.svh"
module tb_top;
   import ddr3_mpr_pkg::*;
   logic clk, rst, wr_s, rd_s; // Clock, reset, strobes
   logic [3:0] ra; // Register address
   logic [15:0] wd, rdat, s; // Write data, read data, status
   logic dev_on; // Device readout mode
   logic [1:0] dev_loc, dev_bl; // Device location and burst field
   logic [7:0] dev_banks; // Device open banks
   int n_errors = 0;
   int checks_done = 0;
   ddr3_link_if #(.DQ_W(8)) link ();
   ddr3_mpr_ctrl #(.DLLK_CYC(4)) ddr3_mpr_ctrl_inst (.core_clk_i(clk), .reset_i(rst), .reg_addr_i(ra),
      .reg_wdata_i(wd), .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdat), .link(link));
   ddr3_mpr_device ddr3_mpr_device_inst (.core_clk_i(clk), .reset_i(rst), .link(link), .readout_mode_o(dev_on),
      .readout_loc_o(dev_loc), .bl_mode_o(dev_bl), .banks_open_o(dev_banks));
   ddr3_mpr_assertions ddr3_mpr_assertions_inst (.core_clk_i(clk), .reset_i(rst), .rst_n(link.rst_n),
      .cs_n(link.cs_n), .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n), .ba(link.ba),
      .addr(link.addr), .dq(link.dq), .dq_dev_oe(link.dq_dev_oe), .dqs_dev(link.dqs_dev));
   // Free running clock
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // Compare and count
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask : chk
   // One cycle register write
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      ra <= a;
      wd <= d;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask : wr
   // Register read, data stands the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk);
      ra <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1;
      d = rdat;
   endtask : rd
   // Poll a status bit under a bounded count
   task automatic wait_stat(input int i, input logic v);
      for (int n = 0; n < 100; n++)
      begin
         rd(`REG_STAT, s);
         if (s[i] === v)
            break;
      end
      chk(16'(s[i]), 16'(v));
   endtask : wait_stat
   // Issue an order, wait, then check the captured beats
   task automatic burst(input logic [15:0] cw, input bit pat, input int n);
      logic [15:0] d;
      wr(`REG_CTRL, cw);
      wait_stat(`SF_BUSY, 1'b0);
      for (int k = 0; k < n; k++)
      begin
         rd(4'(8 + k), d);
         chk(d, pat ? (k[0] ? 16'h00ff : 16'h0000) : 16'(8'h10 + k));
      end
   endtask : burst
   // Verdict and end of run
   task automatic final_report();
      $display("errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : final_report
   // Watchdog against a hang
   initial
   begin
      #400000;
      n_errors++;
      final_report();
   end
   // Main sequence
   initial
   begin
      rst = 1'b1;
      wr_s = 1'b0;
      rd_s = 1'b0;
      ra = 4'h0;
      wd = 16'h0000;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      wait_stat(`SF_LOCK, 1'b1);
      wr(`REG_WDATA, 16'h0010);
      burst(16'h0003, 1'b0, 0);
      burst(16'h0010, 1'b0, 0);
      chk(16'(dev_loc), 16'h0002);
      burst(16'h0002, 1'b0, 8);
      burst(16'h0021, 1'b0, 0);
      chk(16'(dev_bl), 16'h0001);
      wr(`REG_CTRL, 16'h0004);
      wait_stat(`SF_ON, 1'b1);
      chk(16'(dev_on), 16'h0001);
      chk(16'(dev_loc), 16'h0000);
      // Upper nibble first, with column bits set, so capture slots 4 to 7 still hold array data
      burst(16'h1f82, 1'b1, 4);
      rd(4'hc, s);
      chk(s, 16'h0014);
      burst(16'h0082, 1'b1, 4);
      burst(16'h0002, 1'b1, 8);
      chk(16'(dev_banks), 16'h0000);
      wr(`REG_CTRL, 16'h0003);
      rd(`REG_STAT, s);
      chk(16'(s[`SF_REFUSED]), 16'h0001);
      // Reserved location on entry is refused and leaves the device alone
      wr(`REG_CTRL, 16'h000c);
      rd(`REG_STAT, s);
      chk(16'(s[`SF_REFUSED]), 16'h0001);
      chk(16'(dev_loc), 16'h0000);
      wr(`REG_CTRL, 16'h0000);
      wait_stat(`SF_ON, 1'b0);
      wr(`REG_CTRL, 16'h0004);
      wait_stat(`SF_ON, 1'b1);
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      // A read before lock is refused
      wr(`REG_CTRL, 16'h0002);
      rd(`REG_STAT, s);
      chk(16'(s[`SF_REFUSED]), 16'h0001);
      wait_stat(`SF_LOCK, 1'b1);
      rd(`REG_STAT, s);
      chk(16'(s[`SF_ON]), 16'h0000);
      chk(16'(dev_on), 16'h0000);
      final_report();
   end
endmodule : tb_top
`default_nettype wire
